// >>> include/jtp_tap_regs.vh
`ifndef JTP_TAP_REGS_VH
`define JTP_TAP_REGS_VH

// ==========================================================
// widths
`define JTP_IR_W          4
`define JTP_DR_W          32

// ==========================================================
// instruction codes
`define JTP_INS_EXTEST    4'h0
`define JTP_INS_IDCODE    4'h1
`define JTP_INS_SAMPLE    4'h2
`define JTP_INS_USERCODE  4'h3
`define JTP_INS_CHIPTAP   4'h4
`define JTP_INS_FUSE      4'h5
`define JTP_INS_BYPASS    4'hF
`define JTP_IR_CAPTURE    4'h1

// ==========================================================
// security register bits and fields
`define JTP_SEC_PORT_OFF  0
`define JTP_SEC_BOOT_FUSE 5
`define JTP_SEC_FUSE_OFF  13
`define JTP_UTAG_HI       31
`define JTP_UTAG_LO       22
`define JTP_UNUSED_W      6
`define JTP_REV_W         16

// ==========================================================
// arbitrary identity values, not taken from any real part
`define JTP_ID_VERSION    4'h1
`define JTP_ID_PART       16'h0A5C
`define JTP_ID_MAKER      11'h2B5
`define JTP_REV_VALUE     16'h0001

`endif

// >>> rtl/jtp_sync.v
`default_nettype none
// ==========================================================
// two-stage synchroniser for one pin
module jtp_sync (
  input  wire ref_clk_i,
  input  wire arst_n_i,
  input  wire d_i,
  output reg  q_o
);
  reg meta;

  // first stage feeds only the second
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // jtp_sync
`default_nettype wire

// >>> rtl/jtp_test_port.v
`include "jtp_tap_regs.vh"
`default_nettype none
// ==========================================================
// test access port with chip tap path, boot gate
module jtp_test_port (
  input  wire        ref_clk_i,
  input  wire        arst_n_i,
  input  wire        tck_i,
  input  wire        tms_i,
  input  wire        tdi_i,
  input  wire        trst_n_i,
  output reg         tdo_o,
  output reg         tdo_oe_n_o,
  input  wire [31:0] sec_reg_i,
  input  wire [31:0] bscan_pins_i,
  output reg  [31:0] bscan_out_o,
  output reg         bscan_extest_o,
  output reg         chip_tck_o,
  output reg         chip_tms_o,
  output reg         chip_tdi_o,
  output reg         chip_trst_n_o,
  input  wire        chip_tdo_i,
  input  wire [31:0] fuse_rdata_i,
  output reg         fuse_req_o,
  output reg  [31:0] fuse_wdata_o,
  input  wire        pll_lock_i,
  output reg         boot_go_o,
  output reg         boot_fuse_o
);

  // ========================================================
  // controller states
  localparam [3:0] ST_TLR    = 4'h0;
  localparam [3:0] ST_RTI    = 4'h1;
  localparam [3:0] ST_SELDR  = 4'h2;
  localparam [3:0] ST_CAPDR  = 4'h3;
  localparam [3:0] ST_SHDR   = 4'h4;
  localparam [3:0] ST_EX1DR  = 4'h5;
  localparam [3:0] ST_PADR   = 4'h6;
  localparam [3:0] ST_EX2DR  = 4'h7;
  localparam [3:0] ST_UPDDR  = 4'h8;
  localparam [3:0] ST_SELIR  = 4'h9;
  localparam [3:0] ST_CAPIR  = 4'hA;
  localparam [3:0] ST_SHIR   = 4'hB;
  localparam [3:0] ST_EX1IR  = 4'hC;
  localparam [3:0] ST_PAIR   = 4'hD;
  localparam [3:0] ST_EX2IR  = 4'hE;
  localparam [3:0] ST_UPDIR  = 4'hF;

  // ========================================================
  // pin synchronisers
  localparam NSYNC = 6;
  wire [NSYNC-1:0] raw_in;
  wire [NSYNC-1:0] syn;
  assign raw_in = {pll_lock_i, chip_tdo_i, trst_n_i, tdi_i, tms_i, tck_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      jtp_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .d_i       (raw_in[gi]),
        .q_o       (syn[gi])
      );
    end
  endgenerate

  wire tck_s      = syn[0];
  wire tms_s      = syn[1];
  wire tdi_s      = syn[2];
  wire trst_n_s   = syn[3];
  wire chip_tdo_s = syn[4];
  wire lock_s     = syn[5];

  // ========================================================
  // test clock edge detection
  reg tck_d;
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end
  wire tck_rise = tck_s & ~tck_d;
  wire tck_fall = ~tck_s & tck_d;

  // test logic reset: pin low or port disabled
  wire tap_rst = ~trst_n_s | sec_reg_i[`JTP_SEC_PORT_OFF];
  wire fuse_off = sec_reg_i[`JTP_SEC_FUSE_OFF];

  // ========================================================
  // identity and user words
  wire [31:0] id_word = {`JTP_ID_VERSION, `JTP_ID_PART, `JTP_ID_MAKER, 1'b1};
  wire [31:0] user_word = {sec_reg_i[`JTP_UTAG_HI:`JTP_UTAG_LO],
                           {`JTP_UNUSED_W{1'b0}}, `JTP_REV_VALUE};

  // ========================================================
  // controller next state
  reg [3:0] state;
  reg [3:0] next_state;
  always @* begin
    case (state)
      ST_TLR:   next_state = tms_s ? ST_TLR   : ST_RTI;
      ST_RTI:   next_state = tms_s ? ST_SELDR : ST_RTI;
      ST_SELDR: next_state = tms_s ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: next_state = tms_s ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  next_state = tms_s ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: next_state = tms_s ? ST_UPDDR : ST_PADR;
      ST_PADR:  next_state = tms_s ? ST_EX2DR : ST_PADR;
      ST_EX2DR: next_state = tms_s ? ST_UPDDR : ST_SHDR;
      ST_UPDDR: next_state = tms_s ? ST_SELDR : ST_RTI;
      ST_SELIR: next_state = tms_s ? ST_TLR   : ST_CAPIR;
      ST_CAPIR: next_state = tms_s ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  next_state = tms_s ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: next_state = tms_s ? ST_UPDIR : ST_PAIR;
      ST_PAIR:  next_state = tms_s ? ST_EX2IR : ST_PAIR;
      ST_EX2IR: next_state = tms_s ? ST_UPDIR : ST_SHIR;
      default:  next_state = tms_s ? ST_SELDR : ST_RTI;
    endcase
  end

  // ========================================================
  // state, instruction and shift registers
  reg [`JTP_IR_W-1:0] ir;
  reg [`JTP_IR_W-1:0] ir_sh;
  reg [`JTP_DR_W-1:0] dr;
  reg                 bypass_bit;

  wire sel_bypass = (ir == `JTP_INS_BYPASS) ||
                    ((ir == `JTP_INS_FUSE) && fuse_off);
  wire sel_chip   = (ir == `JTP_INS_CHIPTAP);
  wire sel_scan   = (ir == `JTP_INS_EXTEST) || (ir == `JTP_INS_SAMPLE);
  wire sel_fuse   = (ir == `JTP_INS_FUSE) && !fuse_off;

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state      <= ST_TLR;
      ir         <= `JTP_INS_IDCODE;
      ir_sh      <= {`JTP_IR_W{1'b0}};
      dr         <= {`JTP_DR_W{1'b0}};
      bypass_bit <= 1'b0;
    end else if (tap_rst) begin
      state      <= ST_TLR;
      ir         <= `JTP_INS_IDCODE;
      ir_sh      <= {`JTP_IR_W{1'b0}};
      dr         <= {`JTP_DR_W{1'b0}};
      bypass_bit <= 1'b0;
    end else begin
      if (tck_rise) begin
        state <= next_state;
        case (state)
          ST_CAPIR: ir_sh <= `JTP_IR_CAPTURE;
          ST_SHIR:  ir_sh <= {tdi_s, ir_sh[`JTP_IR_W-1:1]};
          ST_CAPDR: begin
            bypass_bit <= 1'b0;
            if (ir == `JTP_INS_IDCODE)
              dr <= id_word;
            else if (ir == `JTP_INS_USERCODE)
              dr <= user_word;
            else if (sel_scan)
              dr <= bscan_pins_i;
            else if (sel_fuse)
              dr <= fuse_rdata_i;
            else
              dr <= {`JTP_DR_W{1'b0}};
          end
          ST_SHDR: begin
            dr         <= {tdi_s, dr[`JTP_DR_W-1:1]};
            bypass_bit <= tdi_s;
          end
          default: ;
        endcase
      end
      // instruction takes effect on the falling edge in update
      if (tck_fall && state == ST_UPDIR)
        ir <= ir_sh;
      else if (tck_fall && state == ST_TLR)
        ir <= `JTP_INS_IDCODE;
    end
  end

  // ========================================================
  // serial output changes on falling test clock
  wire shifting = (state == ST_SHIR) || (state == ST_SHDR);
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tdo_o      <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else if (tap_rst) begin
      tdo_o      <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else if (tck_fall) begin
      tdo_oe_n_o <= ~shifting;
      if (state == ST_SHIR)
        tdo_o <= ir_sh[0];
      else if (sel_chip)
        tdo_o <= chip_tdo_s;
      else if (sel_bypass)
        tdo_o <= bypass_bit;
      else
        tdo_o <= dr[0];
    end
  end

  // ========================================================
  // boundary scan outputs and fuse requests
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bscan_out_o    <= {`JTP_DR_W{1'b0}};
      bscan_extest_o <= 1'b0;
      fuse_req_o     <= 1'b0;
      fuse_wdata_o   <= {`JTP_DR_W{1'b0}};
    end else if (tap_rst) begin
      bscan_extest_o <= 1'b0;
      fuse_req_o     <= 1'b0;
    end else begin
      fuse_req_o     <= 1'b0;
      bscan_extest_o <= (ir == `JTP_INS_EXTEST);
      if (tck_fall && state == ST_UPDDR) begin
        if (sel_scan)
          bscan_out_o <= dr;
        if (sel_fuse) begin
          fuse_req_o   <= 1'b1;
          fuse_wdata_o <= dr;
        end
      end
    end
  end

  // ========================================================
  // path to inner chip tap
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chip_tck_o    <= 1'b0;
      chip_tms_o    <= 1'b1;
      chip_tdi_o    <= 1'b0;
      chip_trst_n_o <= 1'b0;
    end else begin
      chip_trst_n_o <= ~tap_rst;
      chip_tck_o    <= tck_s & sel_chip & ~tap_rst;
      chip_tms_o    <= tms_s;
      chip_tdi_o    <= tdi_s;
    end
  end

  // ========================================================
  // boot start after clock multiplier lock
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_go_o   <= 1'b0;
      boot_fuse_o <= 1'b0;
    end else if (!boot_go_o && lock_s) begin
      boot_go_o   <= 1'b1;
      boot_fuse_o <= sec_reg_i[`JTP_SEC_BOOT_FUSE];
    end
  end

endmodule // jtp_test_port
`default_nettype wire

// >>> verification/jtp_mon_monitor.sv
`default_nettype none
// ==========================================================
// checker on the test port pins
module jtp_mon (
  input wire logic        ref_clk_i,
  input wire logic        arst_n_i,
  input wire logic        trst_n_i,
  input wire logic [31:0] sec_reg_i,
  input wire logic        tdo_oe_n_o,
  input wire logic        chip_trst_n_o,
  input wire logic        fuse_req_o,
  input wire logic        pll_lock_i,
  input wire logic        boot_go_o,
  input wire logic        boot_fuse_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // one domain; global reset mutes all but the reset check
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  property p_rst; disable iff (1'b0)
    !arst_n_i |-> tdo_oe_n_o && !chip_trst_n_o && !fuse_req_o && !boot_go_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs not reset");
  property p_trst; !trst_n_i [*4] |-> tdo_oe_n_o && !chip_trst_n_o; endproperty
  a_trst: assert property (p_trst) else $error("test reset not held");
  property p_off; sec_reg_i[0] [*4] |-> tdo_oe_n_o && !chip_trst_n_o && !fuse_req_o; endproperty
  a_off: assert property (p_off) else $error("port not disabled");
  property p_lock; fuse_req_o |-> !sec_reg_i[13]; endproperty
  a_lock: assert property (p_lock) else $error("fuse access not blocked");
  property p_pulse; fuse_req_o |=> !fuse_req_o; endproperty
  a_pulse: assert property (p_pulse) else $error("fuse request too long");
  property p_boot; $rose(pll_lock_i) && !boot_go_o |-> ##3 $rose(boot_go_o); endproperty
  a_boot: assert property (p_boot) else $error("boot start mistimed");
  property p_mode; $rose(boot_go_o) |-> boot_fuse_o == $past(sec_reg_i[5]); endproperty
  a_mode: assert property (p_mode) else $error("boot mode wrong");
  property p_drive; !tdo_oe_n_o |-> chip_trst_n_o; endproperty
  a_drive: assert property (p_drive) else $error("serial out driven in reset");
endmodule // jtp_mon
bind jtp_test_port jtp_mon u_mon (.*);
`default_nettype wire

// >>> verification/jtp_probe.sv
`default_nettype none
// ==========================================================
// scan controller model driving the test pins
module jtp_probe (
  output var logic tck_o,
  output var logic tms_o,
  output var logic tdi_o,
  output var logic trst_n_o,
  input  wire logic tdo_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // test reset low from power-up, clock still
  initial begin
    {tck_o, tms_o, tdi_o, trst_n_o} = 4'h4;
  end
  // one test clock; serial out taken late in the high phase
  task automatic bit_io(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #100 tck_o = 1'b1;
    #99 q = tdo_i;
    #1 tck_o = 1'b0;
  endtask
  // idle, select, capture, n shifts lsb first, update, idle
  task automatic scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
    logic x;
    q = 32'h0;
    #7 bit_io(1'b0, ~tdi_o, x);
    bit_io(1'b1, ~tdi_o, x);
    if (ir) bit_io(1'b1, ~tdi_o, x);
    bit_io(1'b0, ~tdi_o, x);
    bit_io(1'b0, ~tdi_o, x);
    for (int i = 0; i < n; i++) bit_io(i == n - 1, d[i], q[i]);
    bit_io(1'b1, ~tdi_o, x);
    bit_io(1'b0, ~tdi_o, x);
  endtask
endmodule // jtp_probe
`default_nettype wire

// >>> verification/tb_top.sv
`include "jtp_tap_regs.vh"
`default_nettype none
// ==========================================================
// self-checking bench for the test port
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk_i, arst_n_i, tck, tms, tdi, trst_n, tdo_o, tdo_oe_n_o, chip_tdo_i;
  logic        fuse_req_o, pll_lock_i, boot_go_o, boot_fuse_o, bscan_extest_o;
  logic        chip_tck_o, chip_tms_o, chip_tdi_o, ck_d;
  logic [31:0] sec_reg_i, pins, bscan_out_o, rdata, fuse_wdata_o, rx, w, e, exp_q[$];
  int          error_cnt, compares, oe_low, ck_cnt, lag_bad;
  string       tname;
  event        got;
  wire         tdo_line = tdo_o ^ tdo_oe_n_o; // released line shows the inverse
  localparam logic [31:0] ID = {`JTP_ID_VERSION, `JTP_ID_PART, `JTP_ID_MAKER, 1'b1};
  jtp_probe p (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo_line));
  jtp_test_port dut (.ref_clk_i, .arst_n_i, .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .tdo_o, .tdo_oe_n_o, .sec_reg_i, .bscan_pins_i(pins), .bscan_out_o,
    .bscan_extest_o, .chip_tck_o, .chip_tms_o, .chip_tdi_o, .chip_trst_n_o(),
    .chip_tdo_i, .fuse_rdata_i(rdata), .fuse_req_o, .fuse_wdata_o, .pll_lock_i, .boot_go_o,
    .boot_fuse_o);
  // clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // wait n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask
  // note an expectation and hand the result to the watcher
  task automatic res(input logic [31:0] ex, input logic [31:0] v);
    exp_q.push_back(ex);
    rx = v;
    ->got;
    tick(1);
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] d, input logic [31:0] ex);
    logic [31:0] q;
    tick(1);
    p.scan(ir, n, d, q);
    res(ex, q);
  endtask
  task automatic ir_ld(input logic [3:0] c);
    scan(1'b1, 4, {28'h0, c}, {28'h0, `JTP_IR_CAPTURE});
  endtask
  task automatic next(input string nm);
    $display("finished %s", tname);
    tname = nm;
  endtask
  task automatic end_sim;
    error_cnt += exp_q.size(); // notes never met count as mismatches
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watcher: each result meets the oldest note
  always @(got) begin
    e = exp_q.size() > 0 ? exp_q.pop_front() : 32'hX;
    compares++;
    if (rx !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", tname, e, rx);
    end
  end
  // fuse writes are results too; count driven serial-out cycles
  always @(posedge ref_clk_i) begin
    if (fuse_req_o === 1'b1) begin
      rx = fuse_wdata_o;
      ->got;
    end
    oe_low += (tdo_oe_n_o !== 1'b1);
    // inner tap clock pulses; tms and tdi copies must match the pins
    if (chip_tck_o === 1'b1 && ck_d === 1'b0) begin
      ck_cnt++;
      lag_bad += (chip_tms_o !== tms) + (chip_tdi_o !== tdi);
    end
    ck_d = chip_tck_o;
  end
  // main sequence
  initial begin
    arst_n_i = 1'b1;
    {sec_reg_i, pins, rdata, chip_tdo_i, pll_lock_i} = '0;
    tname = "boot";
    void'($urandom(71872));
    // real falling edge before the first clock, then held 100 ns or more
    #1 arst_n_i = 1'b0;
    tick(5);
    arst_n_i = 1'b1;
    sec_reg_i = $urandom & 32'hFFC0_0020;
    res(32'h0, {30'h0, boot_fuse_o, boot_go_o});
    pll_lock_i = 1'b1;
    tick(3);
    res({30'h0, sec_reg_i[5], 1'b1}, {30'h0, boot_fuse_o, boot_go_o});
    p.trst_n_o = 1'b1;
    next("idcode and usercode");
    scan(1'b0, 32, $urandom, ID);
    ir_ld(`JTP_INS_USERCODE);
    repeat (3) begin
      sec_reg_i = $urandom & 32'hFFC0_0020;
      scan(1'b0, 32, $urandom, {sec_reg_i[31:22], 6'h0, `JTP_REV_VALUE});
    end
    next("bypass boundary chip");
    ir_ld(`JTP_INS_BYPASS);
    w = $urandom;
    scan(1'b0, 32, w, {w[30:0], 1'b0});
    pins = $urandom;
    ir_ld(`JTP_INS_SAMPLE);
    scan(1'b0, 32, w, pins);
    res(w, bscan_out_o);
    ir_ld(`JTP_INS_EXTEST);
    res(32'h1, {31'h0, bscan_extest_o});
    chip_tdo_i = w[0];
    ir_ld(`JTP_INS_CHIPTAP);
    res(32'h0, {31'h0, bscan_extest_o});
    ck_cnt = 0;
    scan(1'b0, 32, $urandom, {32{w[0]}});
    // 4 lead-in, 32 shift and 2 tail test clocks reach the inner tap
    res(32'h26, 32'(ck_cnt));
    res(32'h0, 32'(lag_bad));
    next("fuse");
    ir_ld(`JTP_INS_FUSE);
    for (int k = 0; k < 2; k++) begin
      sec_reg_i[13] = k[0];
      rdata = $urandom;
      w = $urandom;
      if (k == 0) exp_q.push_back(w);
      scan(1'b0, 32, w, k ? {w[30:0], 1'b0} : rdata);
    end
    next("port off and test reset");
    sec_reg_i[0] = 1'b1;
    oe_low = 0;
    p.scan(1'b1, 4, 32'h3, w);
    res(32'h0, 32'(oe_low));
    sec_reg_i[0] = 1'b0;
    scan(1'b0, 32, $urandom, ID);
    ir_ld(`JTP_INS_BYPASS);
    p.trst_n_o = 1'b0;
    tick(8);
    p.trst_n_o = 1'b1;
    scan(1'b0, 32, $urandom, ID);
    next("global reset");
    arst_n_i = 1'b0;
    #1 res(32'h0, {30'h0, boot_fuse_o, boot_go_o});
    arst_n_i = 1'b1;
    tick(6);
    res({30'h0, sec_reg_i[5], 1'b1}, {30'h0, boot_fuse_o, boot_go_o});
    next("end");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
